// ==== bench/ssp_host_model.sv ====
// Purpose: Host controller model for the serial port and keying data
// Assumes: 32 ns serial clock, running only inside frames
// Notes:   A released data line shows the inverse of its last bit
`timescale 1ns/1ns
`default_nettype none
module ssp_host_model (
    output logic      serial_clk,
    output logic      serial_port_select,
    output logic      serial_input_line,
    input  wire logic lock_or_readback_out
);
    // ----------------------------------------------------------------
    // Frame and keying drivers
    // ----------------------------------------------------------------
    initial begin
        serial_clk         = 1'b0;
        serial_port_select = 1'b1;
        serial_input_line  = 1'b1;
        // A falling enable after start clears the frame logic before any frame
        #1 serial_port_select = 1'b0;
    end

    task automatic frame(input logic rw, input logic [5:0] adr, input logic [23:0] dat,
                         input int nbits, output logic [23:0] rdat);
        logic [31:0] w;
        w    = {rw, adr, dat, ~dat[0]};
        rdat = 24'h000000;
        #($urandom_range(15, 1));
        serial_port_select = 1'b1;
        serial_input_line  = w[31];
        #8;
        for (int i = 0; i < nbits; i++) begin
            serial_clk = 1'b1;
            #16;
            serial_clk = 1'b0;
            if (i >= 7 && i <= 30) rdat = {rdat[22:0], lock_or_readback_out};
            if (i < 31) serial_input_line = w[30-i];
            if (i < nbits - 1) #16;
        end
        serial_port_select = 1'b0;
        serial_input_line  = ~serial_input_line;
    endtask : frame

    task automatic key(input logic b);
        #3;
        serial_input_line = b;
    endtask : key

    task automatic hold_select(input logic s);
        #3;
        serial_port_select = s;
    endtask : hold_select
endmodule : ssp_host_model
`default_nettype wire

// ==== bench/ssp_serial_core_bench.sv ====
// Purpose: Self-checking bench of the serial port block
// Assumes: POR_CYCLES of 20, host model on the serial link
// Notes:   Random words from a fixed seed, corner words among them
`timescale 1ns/1ns
`default_nettype none
`include "ssp_map.svh"
module ssp_serial_core_bench
    import ssp_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b0, lock_indicator = 1'b0;
    logic        chip_enable = 1'b1, ref_div_clk = 1'b0;
    logic [1:0]  ref_cnt = 2'h0;
    wire         serial_clk, serial_port_select, serial_input_line, lock_or_readback_out;
    wire         por_done, powered_down, analog_on, dsm_run, fsk_active, fsk_data;
    wire         misload_hazard;
    wire  [6:0]  block_on;
    wire  [16:0] divider_int;
    wire  [23:0] divider_frac;
    wire  [13:0] ref_divider;
    int          mismatches = 0, cmp_count = 0, hz = 0, h0, n;
    ssp_addr_t   a;
    ssp_word_t   d, f, s;
    logic [6:0]  kb;
    logic [24:0] e;

    ssp_serial_core #(.POR_CYCLES(20)) i_ssp_serial_core (
        .clk(clk), .rst(rst), .serial_clk(serial_clk),
        .serial_port_select(serial_port_select), .serial_input_line(serial_input_line),
        .lock_indicator(lock_indicator), .chip_enable(chip_enable),
        .ref_div_clk(ref_div_clk), .lock_or_readback_out(lock_or_readback_out),
        .por_done(por_done), .powered_down(powered_down), .analog_on(analog_on),
        .block_on(block_on), .dsm_run(dsm_run), .divider_int(divider_int),
        .divider_frac(divider_frac), .ref_divider(ref_divider), .fsk_active(fsk_active),
        .fsk_data(fsk_data), .misload_hazard(misload_hazard));

    ssp_host_model i_ssp_host_model (
        .serial_clk(serial_clk), .serial_port_select(serial_port_select),
        .serial_input_line(serial_input_line), .lock_or_readback_out(lock_or_readback_out));

    // ----------------------------------------------------------------
    // Clocks and counters
    // ----------------------------------------------------------------
    always #10 clk = ~clk;
    always @(posedge clk) ref_cnt <= ref_cnt + 2'h1;
    always @(posedge clk) if (ref_cnt == 2'h3) ref_div_clk <= ~ref_div_clk;
    always @(posedge clk) if (misload_hazard === 1'b1) hz <= hz + 1;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic ssp_word_t wmask(input ssp_addr_t ad);
        case (ad)
            `SSP_REG_RDIV: return 24'h003FFF;
            `SSP_REG_INTG: return 24'h00FFFF;
            default:       return 24'hFFFFFF;
        endcase
    endfunction : wmask

    function automatic logic [24:0] keyed(input ssp_word_t fr, input ssp_word_t st,
                                          input logic bit_v);
        return bit_v ? {1'b0, fr} + {1'b0, st} : {1'b0, fr};
    endfunction : keyed

    task automatic chk_word(input string nm, input ssp_word_t ex, input ssp_word_t got);
        cmp_count++;
        if (got !== ex) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string nm, input logic ex, input logic got);
        chk_word(nm, {23'h0, ex}, {23'h0, got});
    endtask : chk_bit

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc

    task automatic wr(input ssp_addr_t ad, input ssp_word_t dv);
        ssp_word_t v;
        i_ssp_host_model.frame(1'b0, ad, dv, 32, v);
        cyc(40);
    endtask : wr

    task automatic rd(input ssp_addr_t ad, input ssp_word_t ex, input string nm);
        ssp_word_t v;
        i_ssp_host_model.frame(1'b1, ad, 24'h000000, 32, v);
        cyc(40);
        chk_word(nm, ex, v);
    endtask : rd

    task automatic fin(input string nm);
        $display("test %s finished", nm);
    endtask : fin

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst <= 1'b1;
        void'($urandom(32'hC485A0B7));
        cyc(1);
        #1 chk_bit("pd_reset", 1'b1, powered_down);
        cyc(1);
        rst <= 1'b0;
        for (n = 0; n < 100 && por_done !== 1'b1; n++) cyc(1);
        if (por_done !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
        cyc(6);
        chk_bit("pd_run", 1'b0, powered_down);
        fin("reset");
        rd(`SSP_REG_ID, `SSP_PART_ID, "id");
        rd(`SSP_REG_RST, {14'h0000, `SSP_RST_DEF}, "rst_def");
        rd(`SSP_REG_INTG, {8'h00, `SSP_INTG_DEF}, "intg_def");
        rd(6'h07, 24'h000000, "unmapped");
        fin("defaults");
        for (n = 0; n < 8; n++) begin
            a = 6'h02 + 6'(n % 4);
            d = (n < 4) ? (ssp_word_t'($urandom()) & wmask(a)) : wmask(a);
            wr(a, d);
            rd(a, d, "reg_back");
            if (a == `SSP_REG_RDIV) chk_word("rdiv", d, {10'h0, ref_divider});
            if (a == `SSP_REG_INTG) chk_word("int", d, {7'h0, divider_int});
            if (a == `SSP_REG_FRAC) chk_word("frac_int", 24'h0, divider_frac);
        end
        chk_bit("dsm_off", 1'b0, dsm_run);
        fin("registers");
        wr(`SSP_REG_INTG, 24'h000074);
        h0 = hz;
        wr(`SSP_REG_INTG, 24'h000080);
        chk_word("hazard", 24'h1, 24'(hz - h0));
        h0 = hz;
        wr(`SSP_REG_SEED, 24'h000000);
        wr(`SSP_REG_FRAC, 24'h000000);
        wr(`SSP_REG_INTG, 24'h0000F4);
        wr(`SSP_REG_INTG, 24'h000074);
        wr(`SSP_REG_SEED, 24'h50894C);
        chk_word("no_hazard", 24'h0, 24'(hz - h0));
        fin("hazard");
        wr(`SSP_REG_FRAC, 24'h123456);
        i_ssp_host_model.frame(1'b0, `SSP_REG_FRAC, 24'hABCDEF, 30, d);
        cyc(40);
        rd(`SSP_REG_FRAC, 24'h123456, "short");
        fin("short");
        lock_indicator <= 1'b1;
        chip_enable    <= 1'b0;
        cyc(10);
        chk_bit("pd_pin", 1'b1, powered_down);
        chk_bit("analog", 1'b0, analog_on);
        chk_bit("lock_pin", 1'b1, lock_or_readback_out);
        rd(`SSP_REG_INTG, 24'hFFFFFF, "rd_pd");
        wr(`SSP_REG_FRAC, 24'h00A5A5);
        chip_enable    <= 1'b1;
        lock_indicator <= 1'b0;
        cyc(10);
        rd(`SSP_REG_FRAC, 24'h00A5A5, "wr_pd");
        kb = 7'($urandom());
        wr(`SSP_REG_RST, 24'h000002);
        chip_enable <= 1'b0;
        cyc(10);
        chk_bit("pin_ign", 1'b0, powered_down);
        wr(`SSP_REG_RST, {15'h0, kb, 2'b00});
        chk_bit("reg_pd", 1'b1, powered_down);
        chk_word("keep_on", {17'h0, kb}, {17'h0, block_on});
        chip_enable <= 1'b1;
        wr(`SSP_REG_RST, 24'h000001);
        fin("power");
        f = ssp_word_t'($urandom());
        s = ssp_word_t'($urandom());
        wr(`SSP_REG_FRAC, f);
        wr(`SSP_REG_SEED, s);
        wr(`SSP_REG_SDCFG, 24'h000007);
        chk_bit("dsm_on", 1'b1, dsm_run);
        for (n = 0; n < 4; n++) begin
            e = keyed(f, s, ~n[0]);
            i_ssp_host_model.key(~n[0]);
            cyc(24);
            chk_bit("fsk_on", 1'b1, fsk_active);
            chk_word("fsk_frac", e[23:0], divider_frac);
            chk_word("fsk_int", 24'h74 + {23'h0, e[24]}, {7'h0, divider_int});
        end
        i_ssp_host_model.key(1'b1);
        cyc(24);
        i_ssp_host_model.hold_select(1'b1);
        cyc(12);
        chk_bit("fsk_stop", 1'b0, fsk_data);
        chk_word("base", f, divider_frac);
        i_ssp_host_model.hold_select(1'b0);
        cyc(12);
        fin("keying");
        wr(`SSP_REG_ID, 24'h000001);
        rd(`SSP_REG_INTG, {8'h00, `SSP_INTG_DEF}, "sw_intg");
        rd(`SSP_REG_SDCFG, 24'h000000, "sw_cfg");
        chk_bit("sw_fsk", 1'b0, fsk_active);
        fin("soft_reset");
        report_and_stop();
    end
endmodule : ssp_serial_core_bench
`default_nettype wire

// ==== core/ssp_map.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the serial port
// Assumes: 32-bit frames, 6-bit register address, 24-bit register data
// Notes:   Definitions only
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define SSP_REG_ID      6'h00
`define SSP_REG_RST     6'h01
`define SSP_REG_RDIV    6'h02
`define SSP_REG_INTG    6'h03
`define SSP_REG_FRAC    6'h04
`define SSP_REG_SEED    6'h05
`define SSP_REG_SDCFG   6'h06

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSP_SWRST_BIT   0
`define SSP_PINSEL_BIT  0
`define SSP_FROMSPI_BIT 1
`define SSP_KEEP_LO     2
`define SSP_KEEP_HI     8
`define SSP_FRACRUN_BIT 0
`define SSP_BUFFRUN_BIT 1
`define SSP_FSKEN_BIT   2
`define SSP_HAZ_HI      15
`define SSP_HAZ_LO      5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SSP_RST_DEF     10'h001
`define SSP_RDIV_DEF    14'h0001
`define SSP_INTG_DEF    16'h00C8
`define SSP_FRAC_DEF    24'h000000
`define SSP_SEED_DEF    24'h000000
`define SSP_SDCFG_DEF   3'h0
`define SSP_PART_ID     24'h5A5A01

// ----------------------------------------------------------------
// Frame edges and timing
// ----------------------------------------------------------------
`define SSP_EDGE_RW     6'h01
`define SSP_EDGE_A0     6'h02
`define SSP_EDGE_A5     6'h07
`define SSP_EDGE_D0     6'h08
`define SSP_EDGE_D23    6'h1F
`define SSP_EDGE_END    6'h20
`define SSP_CLK_PERIOD_NS 20
`define SSP_POR_TIME_NS 250000
`define SSP_POR_CYCLES  (`SSP_POR_TIME_NS / `SSP_CLK_PERIOD_NS)

`endif

// ==== core/ssp_pin_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for outside inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   Output follows only once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module ssp_pin_sync
    import ssp_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    wire  [WIDTH-1:0] q_nxt;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q    <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q    <= q_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Agreement filter
    // ----------------------------------------------------------------
    // One output register keeps a single driver; a bit moves only on agreement
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            assign q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q[i];
        end
    endgenerate
endmodule : ssp_pin_sync
`default_nettype wire

// ==== core/ssp_pkg.sv ====
// Purpose: Shared types of the serial port block
// Assumes: Constants live in ssp_map.svh
// Notes:   Types only
package ssp_pkg;
    typedef logic [5:0]  ssp_addr_t;
    typedef logic [23:0] ssp_word_t;
    typedef enum logic {
        SSP_BOOT_HOLD = 1'b0,
        SSP_BOOT_RUN  = 1'b1
    } ssp_boot_e;
endpackage : ssp_pkg

// ==== core/ssp_serial_core.sv ====
// Purpose: Serial control port, keying, divider words and power control of the synthesizer
// Assumes: serial_clk is the host clock and stops outside frames; clk is 50 MHz
// Notes:   Register words are changed only by committed frames or resets
`timescale 1ns/1ns
`default_nettype none
`include "ssp_map.svh"

// Contract
// - Keying hops frequency from data while enable low
// - Enable high stops keying, base frequency back
// - Data one adds step word to fraction
// - Keying bit sampled on divided reference fall
// - Integer mode: modulator off, integer word only
// - Divider words act at once, unbuffered
// - Flag integer writes clearing all upper ones
// - Power-up delay and soft reset restore defaults
// - Chip enable low powers analog down
// - Writes work in power down, reads silent
// - Register power control and keep-on bits
// - Address zero reads the part identifier
// - First edge samples read or write flag
// - Six address bits on edges two-seven
// - Write data captured on edges eight-31
// - Flag high at first edge means read
// - Read drives 24 bits on edges eight-31
// - Lock indication back on 32nd rising edge
// - Source select bit picks pin or register
// - Write to zero is soft reset strobe
module ssp_serial_core
    import ssp_pkg::*;
#(
    parameter int POR_CYCLES = `SSP_POR_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        serial_clk,
    input  wire logic        serial_port_select,
    input  wire logic        serial_input_line,
    input  wire logic        lock_indicator,
    input  wire logic        chip_enable,
    input  wire logic        ref_div_clk,
    output logic             lock_or_readback_out,
    output logic             por_done,
    output logic             powered_down,
    output logic             analog_on,
    output logic [6:0]       block_on,
    output logic             dsm_run,
    output logic [16:0]      divider_int,
    output logic [23:0]      divider_frac,
    output logic [13:0]      ref_divider,
    output logic             fsk_active,
    output logic             fsk_data,
    output logic             misload_hazard
);
    // ----------------------------------------------------------------
    // Link side: frame capture on the host clock
    // ----------------------------------------------------------------
    logic [5:0]  edge_cnt_r;
    logic        rd_cyc_r;
    ssp_addr_t   addr_sr_r;
    ssp_word_t   data_sr_r;
    logic        rd_drive_r;
    logic        sdo_r;
    ssp_addr_t   cmt_addr_r;
    ssp_word_t   cmt_data_r;
    logic        cmt_tgl_r;
    ssp_word_t   rd_word;
    logic        pd_r;

    wire [5:0]  edge_num  = edge_cnt_r + 6'h01;
    wire        at_rw     = (edge_num == `SSP_EDGE_RW);
    wire        at_addr   = (edge_num >= `SSP_EDGE_A0) && (edge_num <= `SSP_EDGE_A5);
    wire        at_alast  = (edge_num == `SSP_EDGE_A5);
    wire        at_data   = (edge_num >= `SSP_EDGE_D0) && (edge_num <= `SSP_EDGE_D23);
    wire        at_dlast  = (edge_num == `SSP_EDGE_D23);
    wire        at_end    = (edge_num == `SSP_EDGE_END);
    wire        in_frame  = (edge_cnt_r != `SSP_EDGE_END);
    wire        do_commit = at_dlast && !rd_cyc_r;
    wire        rd_addr_w = {addr_sr_r[4:0], serial_input_line} == `SSP_REG_ID;

    // Counter and shifters clear whenever the enable is low, so a frame cut short
    // leaves nothing behind and the next frame starts at edge one
    always_ff @(posedge serial_clk or negedge serial_port_select) begin
        if (!serial_port_select) begin
            edge_cnt_r <= 6'h00;
            rd_cyc_r   <= 1'b0;
            addr_sr_r  <= 6'h00;
            data_sr_r  <= 24'h000000;
            rd_drive_r <= 1'b0;
            sdo_r      <= 1'b0;
        end else begin
            if (in_frame) begin
                edge_cnt_r <= edge_num;
            end
            if (at_rw) begin
                rd_cyc_r <= serial_input_line;
            end
            if (at_addr) begin
                addr_sr_r <= {addr_sr_r[4:0], serial_input_line};
            end
            if (at_alast && rd_cyc_r) begin
                data_sr_r <= rd_word;
            end else if (at_data && rd_cyc_r) begin
                data_sr_r <= {data_sr_r[22:0], 1'b0};
                sdo_r     <= data_sr_r[23];
            end else if (at_data) begin
                data_sr_r <= {data_sr_r[22:0], serial_input_line};
            end
            if (edge_num == `SSP_EDGE_D0) begin
                rd_drive_r <= rd_cyc_r;
            end else if (at_end) begin
                rd_drive_r <= 1'b0;
            end
        end
    end

    // Commit holds address and data until the next full write; the host's
    // next write frame, which cannot commit before its edge 31, gives the system side ample room to take them
    always_ff @(posedge serial_clk or posedge rst) begin
        if (rst) begin
            cmt_addr_r <= 6'h00;
            cmt_data_r <= 24'h000000;
            cmt_tgl_r  <= 1'b0;
        end else if (do_commit) begin
            cmt_addr_r <= addr_sr_r;
            cmt_data_r <= {data_sr_r[22:0], serial_input_line};
            cmt_tgl_r  <= ~cmt_tgl_r;
        end
    end

    // In power down the pin keeps showing lock, so reads return the lock level, not register data
    assign lock_or_readback_out = (rd_drive_r && !pd_r) ? sdo_r : lock_indicator;

    // ----------------------------------------------------------------
    // System side: synchronised pins and commit toggle
    // ----------------------------------------------------------------
    logic       ce_q;
    logic       ref_q;
    logic       sdi_q;
    logic       sen_q;
    logic       tgl_q;
    logic       tgl_seen_r;
    logic       ref_prev_r;

    ssp_pin_sync #(
        .WIDTH (5)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({chip_enable, ref_div_clk, serial_input_line, serial_port_select, cmt_tgl_r}),
        .q   ({ce_q, ref_q, sdi_q, sen_q, tgl_q})
    );

    wire commit_evt = (tgl_q != tgl_seen_r);
    wire ref_fall   = ref_prev_r && !ref_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            tgl_seen_r <= 1'b0;
            ref_prev_r <= 1'b0;
        end else begin
            tgl_seen_r <= tgl_q;
            ref_prev_r <= ref_q;
        end
    end

    // ----------------------------------------------------------------
    // Power-up delay
    // ----------------------------------------------------------------
    logic [13:0] por_cnt_r;
    ssp_boot_e   boot_r;

    wire por_last = (por_cnt_r == 14'(POR_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (rst) begin
            por_cnt_r <= 14'h0000;
            boot_r    <= SSP_BOOT_HOLD;
        end else begin
            case (boot_r)
                SSP_BOOT_HOLD: begin
                    por_cnt_r <= por_cnt_r + 14'h0001;
                    if (por_last) begin
                        boot_r <= SSP_BOOT_RUN;
                    end
                end
                SSP_BOOT_RUN: begin
                    por_cnt_r <= por_cnt_r;
                end
                default: begin
                    boot_r <= SSP_BOOT_HOLD;
                end
            endcase
        end
    end

    assign por_done = (boot_r == SSP_BOOT_RUN);

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [9:0]  rst_reg_r;
    logic [13:0] rdiv_r;
    logic [15:0] intg_r;
    ssp_word_t   frac_r;
    ssp_word_t   seed_r;
    logic [2:0]  sdcfg_r;

    wire wr_evt   = commit_evt && por_done;
    wire wr_id    = wr_evt && (cmt_addr_r == `SSP_REG_ID);
    wire wr_rst   = wr_evt && (cmt_addr_r == `SSP_REG_RST);
    wire wr_rdiv  = wr_evt && (cmt_addr_r == `SSP_REG_RDIV);
    wire wr_intg  = wr_evt && (cmt_addr_r == `SSP_REG_INTG);
    wire wr_frac  = wr_evt && (cmt_addr_r == `SSP_REG_FRAC);
    wire wr_seed  = wr_evt && (cmt_addr_r == `SSP_REG_SEED);
    wire wr_sdcfg = wr_evt && (cmt_addr_r == `SSP_REG_SDCFG);
    wire soft_rst = wr_id && cmt_data_r[`SSP_SWRST_BIT];
    wire to_def   = !por_done || soft_rst;

    always_ff @(posedge clk) begin
        if (rst || to_def) begin
            rst_reg_r <= `SSP_RST_DEF;
            rdiv_r    <= `SSP_RDIV_DEF;
            intg_r    <= `SSP_INTG_DEF;
            frac_r    <= `SSP_FRAC_DEF;
            seed_r    <= `SSP_SEED_DEF;
            sdcfg_r   <= `SSP_SDCFG_DEF;
        end else begin
            if (wr_rst)   rst_reg_r <= cmt_data_r[9:0];
            if (wr_rdiv)  rdiv_r    <= cmt_data_r[13:0];
            if (wr_intg)  intg_r    <= cmt_data_r[15:0];
            if (wr_frac)  frac_r    <= cmt_data_r;
            if (wr_seed)  seed_r    <= cmt_data_r;
            if (wr_sdcfg) sdcfg_r   <= cmt_data_r[2:0];
        end
    end

    // Words are static during a read frame: writes only land after a frame ends
    wire [5:0] rd_sel = {addr_sr_r[4:0], serial_input_line};
    assign rd_word = rd_addr_w                     ? `SSP_PART_ID :
                     (rd_sel == `SSP_REG_RST)      ? {14'h0000, rst_reg_r} :
                     (rd_sel == `SSP_REG_RDIV)     ? {10'h000, rdiv_r} :
                     (rd_sel == `SSP_REG_INTG)     ? {8'h00, intg_r} :
                     (rd_sel == `SSP_REG_FRAC)     ? frac_r :
                     (rd_sel == `SSP_REG_SEED)     ? seed_r :
                     (rd_sel == `SSP_REG_SDCFG)    ? {21'h000000, sdcfg_r} :
                     24'h000000;

    // ----------------------------------------------------------------
    // Power control
    // ----------------------------------------------------------------
    logic [6:0] block_on_r;
    wire pd_nxt = rst_reg_r[`SSP_PINSEL_BIT] ? !ce_q : !rst_reg_r[`SSP_FROMSPI_BIT];

    always_ff @(posedge clk) begin
        if (rst) begin
            pd_r       <= 1'b1;
            block_on_r <= 7'h00;
        end else begin
            pd_r       <= pd_nxt;
            block_on_r <= {7{!pd_nxt}} | rst_reg_r[`SSP_KEEP_HI:`SSP_KEEP_LO];
        end
    end

    assign powered_down = pd_r;
    assign analog_on    = !pd_r;
    assign block_on     = block_on_r;
    assign ref_divider  = rdiv_r;

    // ----------------------------------------------------------------
    // Keying and divider words
    // ----------------------------------------------------------------
    logic        fsk_bit_r;
    logic        haz_r;
    logic [16:0] div_int_r;
    ssp_word_t   div_frac_r;

    wire int_mode = !sdcfg_r[`SSP_FRACRUN_BIT] && !sdcfg_r[`SSP_BUFFRUN_BIT];
    // Keying relies on the host holding the enable line low
    wire fsk_on   = sdcfg_r[`SSP_FSKEN_BIT] && !sen_q && !pd_r;
    wire [24:0] frac_sum = {1'b0, frac_r} + (fsk_bit_r ? {1'b0, seed_r} : 25'h0000000);
    wire haz_nxt  = wr_intg && ((intg_r[`SSP_HAZ_HI:`SSP_HAZ_LO]
                    & cmt_data_r[`SSP_HAZ_HI:`SSP_HAZ_LO]) == 11'h000);

    always_ff @(posedge clk) begin
        if (rst) begin
            fsk_bit_r <= 1'b0;
        end else if (!fsk_on) begin
            fsk_bit_r <= 1'b0;
        end else if (ref_fall) begin
            fsk_bit_r <= sdi_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            haz_r      <= 1'b0;
            div_int_r  <= 17'h00000;
            div_frac_r <= 24'h000000;
        end else begin
            haz_r      <= haz_nxt;
            div_int_r  <= int_mode ? {1'b0, intg_r} : {1'b0, intg_r} + {16'h0000, frac_sum[24]};
            div_frac_r <= int_mode ? 24'h000000 : frac_sum[23:0];
        end
    end

    assign dsm_run        = !int_mode;
    assign divider_int    = div_int_r;
    assign divider_frac   = div_frac_r;
    assign fsk_active     = fsk_on;
    assign fsk_data       = fsk_bit_r;
    assign misload_hazard = haz_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_soft_reset_defs: assert property (soft_rst |=> (intg_r == `SSP_INTG_DEF)
        && (frac_r == `SSP_FRAC_DEF) && (rst_reg_r == `SSP_RST_DEF))
        else $error("soft reset did not restore defaults");

    a_por_release: assert property ((!por_done && por_last) |=> por_done)
        else $error("power-up delay did not end on count");

    a_pd_pin: assert property ((rst_reg_r[`SSP_PINSEL_BIT] && !ce_q) |=> powered_down)
        else $error("chip enable low did not power down");

    a_pd_reg: assert property (!rst_reg_r[`SSP_PINSEL_BIT] && $stable(rst_reg_r)
        |=> powered_down == !$past(rst_reg_r[`SSP_FROMSPI_BIT]))
        else $error("register power control ignored");

    a_fsk_stop: assert property (!fsk_on |=> !fsk_bit_r)
        else $error("keying continued with enable high");

    a_fsk_sample: assert property ((fsk_on && ref_fall) |=> fsk_bit_r == $past(sdi_q))
        else $error("keying bit not taken on reference fall");

    a_fsk_sum: assert property ((fsk_bit_r && !int_mode) |=>
        div_frac_r == 24'($past(frac_r) + $past(seed_r)))
        else $error("step word not added for data one");

    a_int_mode: assert property (int_mode |=> (div_frac_r == 24'h000000) ##0 !$past(dsm_run))
        else $error("integer mode left modulator running");

    a_intg_direct: assert property (wr_intg |=> intg_r == $past(cmt_data_r[15:0])
        ##1 (!int_mode || divider_int == {1'b0, intg_r}))
        else $error("integer write not applied at once");

    a_hazard_flag: assert property (haz_nxt |=> misload_hazard ##1 !misload_hazard || haz_nxt)
        else $error("divider hazard not flagged");

    a_read_end: assert property (@(negedge serial_clk) disable iff (rst)
        (edge_cnt_r == `SSP_EDGE_END) |-> !rd_drive_r)
        else $error("readback still driven after edge 32");

    a_write_commit: assert property (@(posedge serial_clk) disable iff (!serial_port_select || rst)
        do_commit |=> cmt_tgl_r != $past(cmt_tgl_r))
        else $error("full write frame not committed");

    c_soft_reset: cover property (soft_rst);
    c_fsk_hop: cover property (fsk_on && fsk_bit_r);
    c_read: cover property (@(posedge serial_clk) rd_drive_r && rd_cyc_r);
    c_hazard: cover property (misload_hazard);
endmodule : ssp_serial_core
`default_nettype wire
